/* File: hw/cmp_regs.svh */
// Register offsets, field positions, vectors and sizes of the core memory block
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH
`define CMP_OFS_CMD 8'h00
`define CMP_OFS_PC 8'h04
`define CMP_OFS_FSR0 8'h08
`define CMP_OFS_FSR1 8'h0c
`define CMP_OFS_INDF0 8'h10
`define CMP_OFS_INDF1 8'h14
`define CMP_OFS_POWER_CONTROL_REGISTER 8'h18
`define CMP_OFS_WREG 8'h1c
`define CMP_OFS_BSR 8'h20
`define CMP_OFS_STAT 8'h24
`define CMP_OFS_PMLD 8'h28
`define CMP_OFS_INFO 8'h2c
`define CMP_POWER_CONTROL_REGISTER_UNF 0
`define CMP_POWER_CONTROL_REGISTER_OVF 1
`define CMP_POWER_CONTROL_REGISTER_RSTEN 2
`define CMP_CMD_OP 18:16
`define CMP_CMD_TGT 14:0
`define CMP_CMD_LIT 7:0
`define CMP_LD_ADR 26:16
`define CMP_LD_DAT 13:0
`define CMP_LIN_FLD 15:13
`define CMP_LIN_OFS 12:0
`define CMP_LIN_TAG 3'h1
`define CMP_GPR_BYTES 13'h0050
`define CMP_GPR_BASE 7'h20
`define CMP_PM_SEL 15
`define CMP_PC_W 15
`define CMP_PM_AW 11
`define CMP_PM_DW 14
`define CMP_PM_LAST 11'h7ff
`define CMP_DM_AW 12
`define CMP_DM_IW 8
`define CMP_DM_LAST 12'h0ff
`define CMP_STK_LAST 4'hf
`define CMP_STK_FULL 5'h10
`define CMP_RST_VEC 15'h0000
`define CMP_IRQ_VEC 15'h0004
`define CMP_INSN_COUNT 8'h31
`endif

/* File: hw/cmp_pkg.sv */
// Types shared by the core memory block
package cmp_pkg;
  typedef enum logic [2:0] {
    cmp_op_nop,
    cmp_op_call,
    cmp_op_ret,
    cmp_op_irq,
    cmp_op_retfie,
    cmp_op_goto,
    cmp_op_brw,
    cmp_op_return_with_literal
  } cmp_op_t;
  typedef struct packed {
    logic [2:0] status;
    logic [7:0] w;
    logic [4:0] bank_select_register;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
  } cmp_ctx_t;
endpackage

/* File: hw/cmp_core_if.sv */
// Carrier between the core and its return stack and shadow registers
`timescale 1ns/10ps
`include "cmp_regs.svh"
interface cmp_core_if;
  logic push;
  logic pop;
  logic clr;
  logic [`CMP_PC_W-1:0] push_addr;
  logic [`CMP_PC_W-1:0] top_addr;
  logic ovf;
  logic unf;
  logic [4:0] depth;
  logic save;
  cmp_pkg::cmp_ctx_t ctx_in;
  cmp_pkg::cmp_ctx_t ctx_out;
  modport core (output push, pop, clr, push_addr, save, ctx_in,
    input top_addr, ovf, unf, depth, ctx_out);
  modport stk (input push, pop, clr, push_addr, output top_addr, ovf, unf, depth);
  modport shd (input save, ctx_in, output ctx_out);
endinterface

/* File: hw/cmp_stack.sv */
// Sixteen-entry return address stack with overflow and underflow detection
`timescale 1ns/10ps
`include "cmp_regs.svh"
module cmp_stack (
  input wire logic pclk,
  input wire logic presetn,
  cmp_core_if.stk bus
);
  import cmp_pkg::*;

  logic [`CMP_PC_W-1:0] mem [0:`CMP_STK_LAST];
  logic [4:0] depth_r;
  logic [4:0] depth_nxt;

  wire full = depth_r == `CMP_STK_FULL;
  wire empty = depth_r == 5'h00;
  wire do_push = bus.push && !full;
  wire do_pop = bus.pop && !empty;
  wire [3:0] top_idx = depth_r[3:0] - 4'h1;

  assign bus.ovf = bus.push && full;
  assign bus.unf = bus.pop && empty;
  assign bus.depth = depth_r;
  assign bus.top_addr = empty ? `CMP_RST_VEC : mem[top_idx];
  assign depth_nxt = bus.clr ? 5'h00 :
    do_push ? depth_r + 5'h01 :
    do_pop ? depth_r - 5'h01 : depth_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_r <= 5'h00;
    end else begin
      depth_r <= depth_nxt;
    end
  end

  // Own storage, not data memory
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[depth_r[3:0]] <= bus.push_addr;
    end
  end

  stack_overflow_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      bus.push && full && !bus.clr |-> bus.ovf ##1 depth_r == `CMP_STK_FULL)
    else $error("push on full stack not flagged or depth moved");

  stack_lifo_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      do_push && !bus.clr |=> bus.top_addr == $past(bus.push_addr))
    else $error("stack did not return last pushed address");
endmodule

/* File: hw/cmp_shadow.sv */
// Shadow copy of core registers for interrupt context saving
`timescale 1ns/10ps
module cmp_shadow (
  input wire logic pclk,
  input wire logic presetn,
  cmp_core_if.shd bus
);
  import cmp_pkg::*;

  cmp_ctx_t ctx_r;

  assign bus.ctx_out = ctx_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_r <= '0;
    end else if (bus.save) begin
      ctx_r <= bus.ctx_in;
    end
  end

  shadow_save_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      bus.save |=> bus.ctx_out == $past(bus.ctx_in))
    else $error("shadow copy not taken on interrupt entry");
endmodule

/* File: hw/cmp_core_mem.sv */
// Program counter, return stack, indirect pointers and their APB register file
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
`include "cmp_regs.svh"
module cmp_core_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [`CMP_PC_W-1:0] pc,
  output logic sw_reset
);
  import cmp_pkg::*;

  cmp_core_if cif ();

  logic [`CMP_PM_DW-1:0] pm [0:`CMP_PM_LAST];
  logic [7:0] dm [0:`CMP_DM_LAST];
  logic [15:0] fsr_r [2];
  logic [`CMP_PC_W-1:0] pc_r;
  logic [`CMP_PC_W-1:0] pc_nxt;
  logic [7:0] w_r;
  logic [4:0] bsr_r;
  logic [2:0] stat_r;
  logic ovf_r;
  logic unf_r;
  logic rsten_r;
  logic swrst_r;
  logic pready_r;
  logic slverr_r;
  logic wait_r;
  logic [31:0] prdata_r;
  logic [1:0] pm_tgt;
  logic [`CMP_PM_AW-1:0] pm_ad [2];
  logic [`CMP_DM_AW-1:0] dm_ad [2];
  logic [15:0] ctx_fsr [2];
  logic restore;

  cmp_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .bus(cif.stk)
  );

  cmp_shadow u_shadow (
    .pclk(pclk),
    .presetn(presetn),
    .bus(cif.shd)
  );

  // APB phase decode
  wire acc = psel && penable && !pready_r;
  wire done = psel && penable && pready_r;
  wire wr = done && pwrite;

  // Address decode
  wire hit_cmd = paddr == `CMP_OFS_CMD;
  wire hit_pc = paddr == `CMP_OFS_PC;
  wire [1:0] hit_fsr = {paddr == `CMP_OFS_FSR1, paddr == `CMP_OFS_FSR0};
  wire [1:0] hit_indf = {paddr == `CMP_OFS_INDF1, paddr == `CMP_OFS_INDF0};
  wire hit_power_control_register = paddr == `CMP_OFS_POWER_CONTROL_REGISTER;
  wire hit_wreg = paddr == `CMP_OFS_WREG;
  wire hit_bsr = paddr == `CMP_OFS_BSR;
  wire hit_stat = paddr == `CMP_OFS_STAT;
  wire hit_pmld = paddr == `CMP_OFS_PMLD;
  wire hit_info = paddr == `CMP_OFS_INFO;
  wire mapped = |{hit_cmd, hit_pc, hit_fsr, hit_indf, hit_power_control_register, hit_wreg,
    hit_bsr, hit_stat, hit_pmld, hit_info};

  // Per-pointer address generation and storage
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    wire lin = fsr_r[i][`CMP_LIN_FLD] == `CMP_LIN_TAG;
    wire [12:0] bank = fsr_r[i][`CMP_LIN_OFS] / `CMP_GPR_BYTES;
    wire [12:0] slot = fsr_r[i][`CMP_LIN_OFS] % `CMP_GPR_BYTES;
    wire [6:0] ofs = slot[6:0] + `CMP_GPR_BASE;
    assign pm_tgt[i] = fsr_r[i][`CMP_PM_SEL];
    assign pm_ad[i] = fsr_r[i][`CMP_PM_AW-1:0];
    // Linear window folds into 80-byte slices of each bank
    assign dm_ad[i] = lin ? {bank[4:0], ofs} :
      fsr_r[i][`CMP_DM_AW-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fsr_r[i] <= 16'h0000;
      end else if (restore) begin
        fsr_r[i] <= ctx_fsr[i];
      end else if (wr && hit_fsr[i]) begin
        fsr_r[i] <= pwdata[15:0];
      end
    end
  end

  // Indirect access through the addressed pointer
  wire sel = hit_indf[1];
  wire indf = |hit_indf;
  wire pm_acc = |(hit_indf & pm_tgt);
  wire [`CMP_DM_AW-1:0] dma = dm_ad[sel];
  wire [`CMP_PM_AW-1:0] pma = pm_ad[sel];
  wire dm_impl = dma <= `CMP_DM_LAST;
  wire [7:0] dm_rd = dm_impl ? dm[dma[`CMP_DM_IW-1:0]] : 8'h00;
  wire [`CMP_PM_DW-1:0] pm_word = pm[pma];
  wire [7:0] pm_rd = pm_word[7:0];
  wire [7:0] indf_rd = pm_acc ? pm_rd : dm_rd;
  wire dm_we = wr && indf && !pm_acc && dm_impl;
  wire pm_we = wr && hit_pmld;
  wire [`CMP_PM_AW-1:0] ld_adr = pwdata[`CMP_LD_ADR];

  // Program memory target holds the answer back one more cycle
  wire need_wait = pm_acc && !wait_r;
  wire pready_nxt = acc && !need_wait;
  wire wait_nxt = acc && need_wait;

  // Command decode
  wire cmd_go = wr && hit_cmd;
  wire go = cmd_go && !swrst_r;
  cmp_op_t op;
  assign op = cmp_op_t'(pwdata[`CMP_CMD_OP]);
  wire [`CMP_PC_W-1:0] tgt = pwdata[`CMP_CMD_TGT];
  wire [7:0] lit = pwdata[`CMP_CMD_LIT];
  wire is_call = op == cmp_op_call;
  wire is_irq = op == cmp_op_irq;
  assign restore = go && op == cmp_op_retfie;
  wire is_pop = op == cmp_op_ret || op == cmp_op_retfie || op == cmp_op_return_with_literal;
  wire stk_err = cif.ovf || cif.unf;

  assign cif.push = go && (is_call || is_irq);
  assign cif.pop = go && is_pop;
  assign cif.clr = swrst_r;
  assign cif.push_addr = is_irq ? pc_r : pc_r + 15'h0001;
  assign cif.save = go && is_irq;
  assign cif.ctx_in = {stat_r, w_r, bsr_r, fsr_r[0], fsr_r[1]};
  assign ctx_fsr[0] = cif.ctx_out.fsr0;
  assign ctx_fsr[1] = cif.ctx_out.fsr1;

  // Sticky stack flags, set beats clear
  wire power_control_register_wr = wr && hit_power_control_register;
  wire ovf_nxt = cif.ovf || (ovf_r && !(power_control_register_wr && !pwdata[`CMP_POWER_CONTROL_REGISTER_OVF]));
  wire unf_nxt = cif.unf || (unf_r && !(power_control_register_wr && !pwdata[`CMP_POWER_CONTROL_REGISTER_UNF]));

  // Read data select
  wire [31:0] rd_mux =
    hit_pc ? {17'h00000, pc_r} :
    hit_fsr[0] ? {16'h0000, fsr_r[0]} :
    hit_fsr[1] ? {16'h0000, fsr_r[1]} :
    indf ? {24'h000000, indf_rd} :
    hit_power_control_register ? {29'h00000000, rsten_r, ovf_r, unf_r} :
    hit_wreg ? {24'h000000, w_r} :
    hit_bsr ? {27'h0000000, bsr_r} :
    hit_stat ? {29'h00000000, stat_r} :
    hit_info ? {19'h00000, cif.depth, `CMP_INSN_COUNT} :
    32'h00000000;

  // Next program counter
  always_comb begin
    pc_nxt = pc_r;
    if (swrst_r) begin
      pc_nxt = `CMP_RST_VEC;
    end else if (go) begin
      case (op)
        cmp_op_call: pc_nxt = tgt;
        cmp_op_goto: pc_nxt = tgt;
        cmp_op_ret: pc_nxt = cif.top_addr;
        cmp_op_retfie: pc_nxt = cif.top_addr;
        cmp_op_return_with_literal: pc_nxt = cif.top_addr;
        cmp_op_irq: pc_nxt = `CMP_IRQ_VEC;
        cmp_op_brw: pc_nxt = pc_r + 15'h0001 + {7'h00, w_r};
        default: pc_nxt = pc_r;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = slverr_r;
  assign pc = pc_r;
  assign sw_reset = swrst_r;

  // Bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      wait_r <= 1'b0;
      slverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      wait_r <= wait_nxt;
      slverr_r <= pready_nxt && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (pready_nxt) begin
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // Program counter, fifteen bits wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= `CMP_RST_VEC;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // Stack error flags and software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      rsten_r <= 1'b0;
      swrst_r <= 1'b0;
    end else begin
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
      rsten_r <= power_control_register_wr ? pwdata[`CMP_POWER_CONTROL_REGISTER_RSTEN] : rsten_r;
      swrst_r <= stk_err && rsten_r;
    end
  end

  // Core working registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_r <= 8'h00;
    end else if (restore) begin
      w_r <= cif.ctx_out.w;
    end else if (go && op == cmp_op_return_with_literal) begin
      w_r <= lit;
    end else if (wr && hit_wreg) begin
      w_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsr_r <= 5'h00;
      stat_r <= 3'h0;
    end else if (restore) begin
      bsr_r <= cif.ctx_out.bank_select_register;
      stat_r <= cif.ctx_out.status;
    end else begin
      bsr_r <= (wr && hit_bsr) ? pwdata[4:0] : bsr_r;
      stat_r <= (wr && hit_stat) ? pwdata[2:0] : stat_r;
    end
  end

  // Program memory loader; address bits above 07FFh dropped
  always_ff @(posedge pclk) begin
    if (pm_we) begin
      pm[ld_adr] <= pwdata[`CMP_LD_DAT];
    end
  end

  always_ff @(posedge pclk) begin
    if (dm_we) begin
      dm[dma[`CMP_DM_IW-1:0]] <= pwdata[7:0];
    end
  end

  irq_vector_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      go && is_irq && !swrst_r |=> pc_r == `CMP_IRQ_VEC)
    else $error("interrupt entry did not vector to 0004h");

  soft_reset_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      stk_err && rsten_r |=> swrst_r ##1 (pc_r == `CMP_RST_VEC && cif.depth == 5'h00))
    else $error("stack error with reset option did not reset");

  ovf_sticky_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      cif.ovf |=> ovf_r && cif.depth == $past(cif.depth))
    else $error("overflow flag not set");

  pm_wait_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      acc && pm_acc && !wait_r |=> !pready_r ##1 pready_r)
    else $error("program memory access did not take one extra cycle");

  pm_low_byte_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      pready_nxt && pm_acc && !pwrite
      |=> prdata_r == {24'h000000, $past(pm_rd)})
    else $error("program read returned more than low byte");

  pm_no_write_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      wr && indf && pm_acc |-> !dm_we && !pm_we)
    else $error("indirect write reached memory while aimed at program");

  unimpl_zero_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      pready_nxt && !pwrite && indf && !pm_acc && !dm_impl |=> prdata_r == 32'h00000000)
    else $error("unimplemented data location read nonzero");

  retfie_restore_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      restore |=> w_r == $past(cif.ctx_out.w) && fsr_r[0] == $past(cif.ctx_out.fsr0))
    else $error("interrupt return did not restore context");

  call_push_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      go && is_call && cif.depth != `CMP_STK_FULL
      |=> cif.depth == $past(cif.depth) + 5'h01 && pc_r == $past(tgt))
    else $error("call did not push and jump");

  ret_pop_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      go && is_pop && cif.depth != 5'h00
      |=> cif.depth == $past(cif.depth) - 5'h01 && pc_r == $past(cif.top_addr))
    else $error("return did not pop into program counter");

  unf_sticky_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      cif.unf |=> unf_r)
    else $error("underflow flag not set");

  fsr_write_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_fsr[0] |=> fsr_r[0] == $past(pwdata[15:0]))
    else $error("pointer write did not land");
endmodule

/* File: verif/cmp_core_mem_test.sv */
// Self-checking bench for the core memory block driven over APB
`timescale 1ns/10ps
`include "cmp_regs.svh"
module cmp_core_mem_test;
  import cmp_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic eexp;
  } cmp_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [`CMP_PC_W-1:0] pc;
  logic sw_reset;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [31:0] q;
  logic e;
  cmp_row_t rows [0:10];
  logic [7:0] ca [0:4];
  logic [31:0] cv [0:4];

  cmp_core_mem u_cmp_core_mem (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc(pc), .sw_reset(sw_reset));

  always #2 pclk = ~pclk;

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task cmd(input cmp_op_t op, input logic [14:0] t);
    wr(`CMP_OFS_CMD, {13'h0, op, 1'b0, t});
    @(posedge pclk);
  endtask

  task chkpc(input logic [14:0] exp);
    chk({17'h0, pc}, {17'h0, exp}, "program counter");
  endtask

  task chkrd(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(q, exp, "register read");
  endtask

  initial begin
    int seen;
    rows = '{
      '{`CMP_OFS_FSR0, 32'hffff_1234, 32'h0000_1234, 1'b0},
      '{`CMP_OFS_FSR1, 32'h0001_8abc, 32'h0000_8abc, 1'b0},
      '{`CMP_OFS_WREG, 32'h0000_01ff, 32'h0000_00ff, 1'b0},
      '{`CMP_OFS_BSR, 32'h0000_00ff, 32'h0000_001f, 1'b0},
      '{`CMP_OFS_STAT, 32'h0000_00ff, 32'h0000_0007, 1'b0},
      '{`CMP_OFS_PC, 32'h0000_7fff, 32'h0000_0000, 1'b0},
      '{`CMP_OFS_INFO, 32'hffff_ffff, 32'h0000_0031, 1'b0},
      '{`CMP_OFS_POWER_CONTROL_REGISTER, 32'h0000_0004, 32'h0000_0004, 1'b0},
      '{`CMP_OFS_POWER_CONTROL_REGISTER, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{8'h30, 32'h0000_00aa, 32'h0000_0000, 1'b1},
      '{8'hfc, 32'h0000_00aa, 32'h0000_0000, 1'b1}};
    ca = '{`CMP_OFS_WREG, `CMP_OFS_BSR, `CMP_OFS_STAT, `CMP_OFS_FSR0, `CMP_OFS_FSR1};
    cv = '{32'h11, 32'h3, 32'h5, 32'h1111, 32'h2222};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chkpc(15'h0000);
    for (int i = 0; i <= 10; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      chk({31'h0, e}, {31'h0, rows[i].eexp}, "write error flag");
      rd(rows[i].addr);
      chk(q, rows[i].rexp, "table read");
      chk({31'h0, e}, {31'h0, rows[i].eexp}, "read error flag");
    end
    $display("table test done");
    cmd(cmp_op_nop, 15'h0123);
    chkpc(15'h0000);
    cmd(cmp_op_call, 15'h0100);
    chkpc(15'h0100);
    cmd(cmp_op_call, 15'h7fff);
    chkpc(15'h7fff);
    chkrd(`CMP_OFS_INFO, 32'h0000_0231);
    cmd(cmp_op_ret, 15'h0);
    chkpc(15'h0101);
    cmd(cmp_op_ret, 15'h0);
    chkpc(15'h0001);
    cmd(cmp_op_ret, 15'h0);
    chkpc(15'h0000);
    chkrd(`CMP_OFS_POWER_CONTROL_REGISTER, 32'h0000_0001);
    wr(`CMP_OFS_POWER_CONTROL_REGISTER, 32'h0);
    wr(`CMP_OFS_WREG, 32'h3);
    cmd(cmp_op_goto, 15'h0010);
    cmd(cmp_op_brw, 15'h0);
    chkpc(15'h0014);
    cmd(cmp_op_call, 15'h0200);
    cmd(cmp_op_return_with_literal, 15'h005a);
    chkpc(15'h0015);
    chkrd(`CMP_OFS_WREG, 32'h5a);
    for (int i = 0; i < 5; i++) wr(ca[i], cv[i]);
    cmd(cmp_op_irq, 15'h0);
    chkpc(`CMP_IRQ_VEC);
    for (int i = 0; i < 5; i++) wr(ca[i], 32'h0);
    cmd(cmp_op_retfie, 15'h0);
    chkpc(15'h0015);
    for (int i = 0; i < 5; i++) chkrd(ca[i], cv[i]);
    $display("stack test done");
    for (int k = 0; k < 2; k++) begin
      wr(`CMP_OFS_POWER_CONTROL_REGISTER, 32'h4);
      if (k == 0) begin
        for (int j = 0; j < 16; j++) cmd(cmp_op_call, 15'(j));
        chkrd(`CMP_OFS_INFO, 32'h0000_1031);
        cmd(cmp_op_call, 15'h0333);
      end else begin
        cmd(cmp_op_ret, 15'h0);
      end
      seen = 0;
      for (int m = 0; m < 4; m++) begin
        if (sw_reset === 1'b1) seen++;
        @(posedge pclk);
      end
      chk(32'(seen), 32'd1, "software reset pulse");
      chkpc(`CMP_RST_VEC);
      chkrd(`CMP_OFS_INFO, 32'h0000_0031);
      rd(`CMP_OFS_POWER_CONTROL_REGISTER);
      chk(q & 32'h3, (k == 0) ? 32'h2 : 32'h1, "stack fault flag");
      wr(`CMP_OFS_POWER_CONTROL_REGISTER, 32'h0);
    end
    $display("stack fault test done");
    wr(`CMP_OFS_PMLD, 32'h0005_3ea5);
    wr(`CMP_OFS_PMLD, 32'h07ff_0123);
    wr(`CMP_OFS_FSR0, 32'h8805);
    chkrd(`CMP_OFS_INDF0, 32'ha5);
    chk(32'(n), 32'd3, "program memory wait");
    wr(`CMP_OFS_INDF0, 32'h00);
    chk(32'(n), 32'd3, "program memory write wait");
    chkrd(`CMP_OFS_INDF0, 32'ha5);
    wr(`CMP_OFS_FSR1, 32'hffff);
    chkrd(`CMP_OFS_INDF1, 32'h23);
    wr(`CMP_OFS_FSR1, 32'h2055);
    wr(`CMP_OFS_INDF1, 32'h77);
    wr(`CMP_OFS_FSR0, 32'h10a5);
    chkrd(`CMP_OFS_INDF0, 32'h77);
    chk(32'(n), 32'd2, "data memory wait");
    wr(`CMP_OFS_FSR0, 32'h0100);
    chkrd(`CMP_OFS_INDF0, 32'h0);
    $display("pointer test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    chk({31'h0, pready}, 32'h0, "ready in reset");
    presetn <= 1'b1;
    chkpc(`CMP_RST_VEC);
    for (int i = 0; i < 5; i++) chkrd(ca[i], 32'h0);
    chkrd(`CMP_OFS_POWER_CONTROL_REGISTER, 32'h0);
    chkrd(`CMP_OFS_INFO, 32'h0000_0031);
    $display("reset test done");
    end_of_test();
  end
endmodule
